// ### verilog/addressable_tap_switch.sv
// Connect-status logic of an addressable test-port switch.
// Assumes a test master on the upstream port, a board chain downstream,
// and a board clock clk that only watches the status.
//
// What this block does
// R1: link_active_n low in forced, forced-reset, multicast, on; else high.
// R2: Upstream test clock always drives downstream test clock.
// R3: Upstream test reset always drives downstream test reset.
// R4: Forced link low selects forced or forced-reset status, data passed.
// R5: Forced-reset status holds mode select high; forced passes it.
// R6: Releasing test reset under forced link returns to forced status.
// R7: Master keeps mode select high five clocks after test reset.
// R8: Frames arrive on data in, acks leave data out, mode select static.
// R9: Frames only in stable TAP states other than the shift states.
// R10: Data in sampled on rising test clock edge.
// R11: Ack data changes on falling test clock edge.
// R12: Received address compared with board id, most significant first.
// R13: Match sends ack first, then enters on status.
// R14: New status applied only once any ack has finished.
// R15: Frame-driven status changes are synchronous to the test clock.
// R16: No-match, drop-all or hard error gives off, mode select held.
// R17: Untolerated protocol variation is a hard error, no ack.
// R18: Multicast passes mode and data but not data out.
// R19: Reset statuses hold downstream mode select high.
// R20: Low test reset clears switch state to power-up condition.
// R21: Forced link acts asynchronously; frames ignored while it is low.
// R22: Group sync only in pause states; drop-all, reset-all global.
// R23: After power-up the switch sits in reset status, outputs off.
// R24: Status held in one encoded register, cleared by test reset.
`timescale 1ns/1ps
module addressable_tap_switch #(
  parameter int ADDR_BITS = tap_switch_pkg::ADDR_WIDTH
) (
  input  wire logic                            clk,
  input  wire logic                            arst_n,
  input  wire logic                            clk_en,
  input  wire logic                            upstream_test_clock,
  input  wire logic                            upstream_test_reset,
  input  wire logic                            upstream_mode_select,
  input  wire logic                            upstream_data_in,
  input  wire logic                            forced_link_n,
  input  wire logic [ADDR_BITS-1:0]            board_id_pins,
  input  wire logic                            downstream_data_in,
  output logic                                 downstream_test_clock,
  output logic                                 downstream_test_reset,
  output logic                                 downstream_mode_select,
  output logic                                 downstream_data_out,
  output logic                                 downstream_data_out_oe,
  output logic                                 upstream_data_out,
  output logic                                 upstream_data_out_oe,
  output logic                                 link_active_n,
  output tap_switch_pkg::link_status_type      monitor_status
);
  import tap_switch_pkg::*;

  // ****************************************************************
  // Link side, upstream test clock domain
  // ****************************************************************
  logic                 tck;
  logic                 trst_n;
  tap_state_type        tap;
  link_status_type      link_state;
  link_status_type      eff_status;
  shadow_state_type     sh_state;
  logic [4:0]           half_cnt;
  logic [ADDR_BITS-1:0] rx_addr;
  logic [ADDR_BITS-1:0] next_addr;
  logic [ADDR_BITS-1:0] ack_shift;
  logic [ADDR_BITS-1:0] id_meta;
  logic [ADDR_BITS-1:0] id_sync;
  logic                 forced_meta;
  logic                 forced_sync;
  logic                 first_half;
  logic                 ms_start;
  logic                 ms_hold;
  logic                 ack_out;
  logic                 ack_oe;
  logic                 tap_stable;
  logic                 tap_pause;
  logic                 shadow_allowed;

  assign tck    = upstream_test_clock;
  assign trst_n = upstream_test_reset;

  // R2: clock straight through
  assign downstream_test_clock = tck;
  // R3: reset straight through
  assign downstream_test_reset = trst_n;

  // Strap and forced-link synchronisers
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      id_meta     <= '0;
      id_sync     <= '0;
      forced_meta <= 1'b1;
      forced_sync <= 1'b1;
    end else begin
      id_meta     <= board_id_pins;
      id_sync     <= id_meta;
      forced_meta <= forced_link_n;
      forced_sync <= forced_meta;
    end
  end

  // R9: TAP controller follower
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tap <= tap_reset;
    end else begin
      case (tap)
        tap_reset:     tap <= upstream_mode_select ? tap_reset : tap_idle;
        tap_idle:      tap <= upstream_mode_select ? tap_sel_dr : tap_idle;
        tap_sel_dr:    tap <= upstream_mode_select ? tap_sel_ir : tap_cap_dr;
        tap_cap_dr:    tap <= upstream_mode_select ? tap_exit1_dr
                                                   : tap_shift_dr;
        tap_shift_dr:  tap <= upstream_mode_select ? tap_exit1_dr
                                                   : tap_shift_dr;
        tap_exit1_dr:  tap <= upstream_mode_select ? tap_update_dr
                                                   : tap_pause_dr;
        tap_pause_dr:  tap <= upstream_mode_select ? tap_exit2_dr
                                                   : tap_pause_dr;
        tap_exit2_dr:  tap <= upstream_mode_select ? tap_update_dr
                                                   : tap_shift_dr;
        tap_update_dr: tap <= upstream_mode_select ? tap_sel_dr : tap_idle;
        tap_sel_ir:    tap <= upstream_mode_select ? tap_reset : tap_cap_ir;
        tap_cap_ir:    tap <= upstream_mode_select ? tap_exit1_ir
                                                   : tap_shift_ir;
        tap_shift_ir:  tap <= upstream_mode_select ? tap_exit1_ir
                                                   : tap_shift_ir;
        tap_exit1_ir:  tap <= upstream_mode_select ? tap_update_ir
                                                   : tap_pause_ir;
        tap_pause_ir:  tap <= upstream_mode_select ? tap_exit2_ir
                                                   : tap_pause_ir;
        tap_exit2_ir:  tap <= upstream_mode_select ? tap_update_ir
                                                   : tap_shift_ir;
        tap_update_ir: tap <= upstream_mode_select ? tap_sel_dr : tap_idle;
        default:       tap <= tap_reset;
      endcase
    end
  end

  // R9: stable states where a frame may run
  assign tap_pause  = (tap == tap_pause_dr) || (tap == tap_pause_ir);
  assign tap_stable = (tap == tap_reset) || (tap == tap_idle) || tap_pause;
  // R21: frames ignored under forced link
  assign shadow_allowed = forced_sync && tap_stable;

  // Address shifted in, most significant first
  assign next_addr = {rx_addr[ADDR_BITS-2:0], first_half};

  // R8: frame receiver, ack sequencer and status register
  // R10: every sample taken on the rising edge
  // R15: status changes only on this edge
  // R20: R24: status register cleared by test reset
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      sh_state   <= sh_idle;
      half_cnt   <= 5'h00;
      rx_addr    <= '0;
      ack_shift  <= '0;
      first_half <= 1'b0;
      ms_start   <= 1'b0;
      // R23: power-up status
      link_state <= ls_reset;
    end else begin
      case (sh_state)
        sh_idle: begin
          // Start bit is a low level on data in
          if (shadow_allowed && !upstream_data_in) begin
            sh_state <= sh_recv;
            half_cnt <= 5'h00;
            ms_start <= upstream_mode_select;
          end
        end
        sh_recv: begin
          half_cnt <= half_cnt + 5'h01;
          if (!forced_sync) begin
            sh_state <= sh_idle;
          // R17: mode select moved, hard error
          end else if (upstream_mode_select != ms_start) begin
            sh_state   <= sh_idle;
            link_state <= ls_off;
          end else if (!half_cnt[0]) begin
            first_half <= upstream_data_in;
          // R17: bit pair not complementary, hard error
          end else if (upstream_data_in == first_half) begin
            sh_state   <= sh_idle;
            link_state <= ls_off;
          end else begin
            rx_addr <= next_addr;
            if (half_cnt == HALF_BITS_LAST) begin
              sh_state <= sh_idle;
              // R22: global codes before the own address
              if (next_addr == DROP_ALL_CODE) begin
                link_state <= ls_off;
              end else if (next_addr == RESET_ALL_CODE) begin
                link_state <= ls_reset;
              end else if (next_addr == GROUP_SYNC_CODE) begin
                link_state <= tap_pause ? ls_multicast : ls_off;
              // R12: compare with board id
              end else if (next_addr == id_sync) begin
                // R13: acknowledge before connecting
                sh_state  <= sh_ack;
                half_cnt  <= 5'h00;
                ack_shift <= id_sync;
              end else begin
                // R16: no match disconnects
                link_state <= ls_off;
              end
            end
          end
        end
        sh_ack: begin
          half_cnt <= half_cnt + 5'h01;
          if (half_cnt[0]) begin
            ack_shift <= {ack_shift[ADDR_BITS-2:0], 1'b0};
          end
          // R14: connect once the ack is done
          if (half_cnt == HALF_BITS_LAST) begin
            sh_state   <= sh_idle;
            link_state <= ls_on;
          end
        end
        default: sh_state <= sh_idle;
      endcase
    end
  end

  // R11: ack bits change on the falling edge
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ack_out <= LINE_IDLE;
      ack_oe  <= 1'b0;
    end else begin
      ack_oe  <= (sh_state == sh_ack);
      ack_out <= (sh_state == sh_ack)
                 ? (ack_shift[ADDR_BITS-1] ^ half_cnt[0]) : LINE_IDLE;
    end
  end

  // R21: forced link overrides without any clock
  // R4: forced statuses chosen by test reset
  always_comb begin
    if (!forced_link_n) begin
      // R6: release of reset goes straight back
      eff_status = trst_n ? ls_forced : ls_forced_trst;
    end else if (!trst_n) begin
      eff_status = ls_trst;
    end else begin
      eff_status = link_state;
    end
  end

  // Last mode select level, held through off status
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ms_hold <= MS_HOLD_RESET;
    end else if (eff_status != ls_off) begin
      ms_hold <= downstream_mode_select;
    end
  end

  // Downstream mode select per status
  always_comb begin
    case (eff_status)
      // R5: pass through in forced status
      ls_forced, ls_on, ls_multicast:
        downstream_mode_select = upstream_mode_select;
      // R16: held level while off
      ls_off:
        downstream_mode_select = ms_hold;
      // R5: R19: high in reset statuses
      default:
        downstream_mode_select = 1'b1;
    endcase
  end

  // R4: R18: data paths and enables
  always_comb begin
    downstream_data_out    = upstream_data_in;
    downstream_data_out_oe = 1'b0;
    upstream_data_out      = ack_out;
    upstream_data_out_oe   = 1'b0;
    link_active_n          = 1'b1;
    case (eff_status)
      ls_forced, ls_forced_trst, ls_on: begin
        downstream_data_out_oe = 1'b1;
        upstream_data_out      = downstream_data_in;
        upstream_data_out_oe   = 1'b1;
        // R1: active
        link_active_n          = 1'b0;
      end
      ls_multicast: begin
        downstream_data_out_oe = 1'b1;
        link_active_n          = 1'b0;
      end
      default: begin
        // R16: R18: R23: only an ack may drive
        upstream_data_out_oe = ack_oe;
      end
    endcase
  end

  // ****************************************************************
  // Status crossing into the board clock domain
  // ****************************************************************
  link_status_type mirror_status;
  logic            mirror_toggle;

  // Capture status and flag a change with a toggle
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      mirror_status <= ls_trst;
      mirror_toggle <= 1'b0;
    end else if (mirror_status != eff_status) begin
      mirror_status <= eff_status;
      mirror_toggle <= ~mirror_toggle;
    end
  end

  logic [1:0] rst_pipe;
  logic       rst_n;
  logic       tog_meta;
  logic       tog_sync;
  logic       tog_seen;

  // Reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Toggle synchroniser and status capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_meta       <= 1'b0;
      tog_sync       <= 1'b0;
      tog_seen       <= 1'b0;
      monitor_status <= ls_reset;
    end else if (clk_en) begin
      tog_meta <= mirror_toggle;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
      if (tog_sync != tog_seen) begin
        monitor_status <= mirror_status;
      end
    end
  end

endmodule : addressable_tap_switch

// ### shared/tap_switch_pkg.sv
// Constants and types of the addressable test-port switch.
// Assumes one switch per board on a multidrop test backplane.
package tap_switch_pkg;

  // ****************************************************************
  // Address frame
  // ****************************************************************
  localparam int         ADDR_WIDTH      = 10;
  // Half-bit count of a frame, last index
  localparam logic [4:0] HALF_BITS_LAST  = 5'h13;
  // Reserved global codes
  localparam logic [9:0] DROP_ALL_CODE   = 10'h000;
  localparam logic [9:0] RESET_ALL_CODE  = 10'h3FF;
  localparam logic [9:0] GROUP_SYNC_CODE = 10'h3FE;
  // Reset values
  localparam logic       MS_HOLD_RESET   = 1'b1;
  localparam logic       LINE_IDLE       = 1'b1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [15:0] {
    tap_reset      = 16'h0001,
    tap_idle       = 16'h0002,
    tap_sel_dr     = 16'h0004,
    tap_cap_dr     = 16'h0008,
    tap_shift_dr   = 16'h0010,
    tap_exit1_dr   = 16'h0020,
    tap_pause_dr   = 16'h0040,
    tap_exit2_dr   = 16'h0080,
    tap_update_dr  = 16'h0100,
    tap_sel_ir     = 16'h0200,
    tap_cap_ir     = 16'h0400,
    tap_shift_ir   = 16'h0800,
    tap_exit1_ir   = 16'h1000,
    tap_pause_ir   = 16'h2000,
    tap_exit2_ir   = 16'h4000,
    tap_update_ir  = 16'h8000
  } tap_state_type;

  typedef enum logic [6:0] {
    ls_reset       = 7'h01,
    ls_trst        = 7'h02,
    ls_off         = 7'h04,
    ls_on          = 7'h08,
    ls_multicast   = 7'h10,
    ls_forced      = 7'h20,
    ls_forced_trst = 7'h40
  } link_status_type;

  typedef enum logic [2:0] {
    sh_idle = 3'h1,
    sh_recv = 3'h2,
    sh_ack  = 3'h4
  } shadow_state_type;

endpackage : tap_switch_pkg

// ### tb/board_chain_model.sv
// Board-level scan chain model behind the switch.
// Assumes one bypass stage clocked by the downstream test clock.
`timescale 1ns/1ps
module board_chain_model (
  input  wire logic tck,
  input  wire logic rst_n,
  input  wire logic tdi,
  input  wire logic tdi_oe,
  output logic      tdo
);
  logic stage = 1'b0;

  // Capture stage; an undriven input is seen toggling
  always @(posedge tck or negedge rst_n)
    if (!rst_n) stage <= 1'b0;
    else stage <= tdi_oe ? tdi : ~stage;

  // Output moves on the falling edge only
  always @(negedge tck) tdo <= stage;

  initial tdo = 1'b0;
endmodule : board_chain_model

// ### tb/tap_switch_chk.sv
// Concurrent checks on the pins of the addressable test-port switch.
// Assumes binding onto the switch; clk runs faster than the test clock.
`timescale 1ns/1ps
module tap_switch_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic upstream_test_clock,
  input wire logic upstream_test_reset,
  input wire logic upstream_mode_select,
  input wire logic upstream_data_in,
  input wire logic forced_link_n,
  input wire logic downstream_test_clock,
  input wire logic downstream_test_reset,
  input wire logic downstream_mode_select,
  input wire logic downstream_data_out,
  input wire logic downstream_data_out_oe,
  input wire logic upstream_data_out_oe,
  input wire logic link_active_n
);
  // ********************
  // Sequences
  // ********************
  sequence quiet_link;
    forced_link_n && link_active_n && !upstream_data_out_oe;
  endsequence
  sequence link_up;
    forced_link_n && !link_active_n;
  endsequence

  // ********************
  // Assertions
  // ********************
  AST_CLOCK_PASS: assert property (
    @(posedge clk) disable iff (!arst_n)
    downstream_test_clock == upstream_test_clock) else $error("clock");
  AST_RESET_PASS: assert property (
    @(posedge clk) disable iff (!arst_n)
    downstream_test_reset == upstream_test_reset) else $error("reset");
  AST_FORCED_LINK: assert property (
    @(posedge clk) disable iff (!arst_n) !forced_link_n |->
    !link_active_n && downstream_data_out_oe && upstream_data_out_oe)
    else $error("forced link");
  AST_FORCED_TRST_MS: assert property (
    @(posedge clk) disable iff (!arst_n)
    !forced_link_n && !upstream_test_reset |-> downstream_mode_select)
    else $error("forced reset mode");
  AST_TRST_QUIET: assert property (
    @(posedge clk) disable iff (!arst_n)
    forced_link_n && !upstream_test_reset |-> link_active_n &&
    downstream_mode_select && !downstream_data_out_oe &&
    !upstream_data_out_oe) else $error("test reset state");
  AST_IDLE_NO_DRIVE: assert property (
    @(posedge clk) disable iff (!arst_n)
    link_active_n |-> !downstream_data_out_oe) else $error("idle drive");
  AST_DATA_PASS: assert property (
    @(posedge clk) disable iff (!arst_n)
    !link_active_n && upstream_test_reset |->
    downstream_data_out == upstream_data_in &&
    downstream_mode_select == upstream_mode_select) else $error("pass");
  AST_SYNC_CHANGE: assert property (
    @(posedge clk) disable iff (!arst_n)
    forced_link_n && $past(forced_link_n) && upstream_test_reset &&
    $past(upstream_test_reset) && $changed(link_active_n) |->
    $rose(upstream_test_clock)) else $error("async status change");
  AST_ON_AFTER_ACK: assert property (
    @(posedge upstream_test_clock) disable iff (!upstream_test_reset)
    quiet_link ##1 link_up |-> !upstream_data_out_oe)
    else $error("link without ack");
  AST_MS_HOLD: assert property (
    @(posedge clk) disable iff (!arst_n)
    link_active_n && $past(link_active_n) && forced_link_n &&
    $past(forced_link_n) && upstream_test_reset &&
    $past(upstream_test_reset) |-> $stable(downstream_mode_select))
    else $error("mode select moved");
endmodule : tap_switch_chk

// ### tb/testbench.sv
// Self-checking bench of the addressable test-port switch.
// Assumes the board chain model and the checker are compiled first.
`timescale 1ns/1ps
module testbench;
  import tap_switch_pkg::*;
  localparam logic [9:0] MY_ID = 10'h2A5;
  localparam logic [9:0] CODES [4] =
    '{DROP_ALL_CODE, MY_ID, GROUP_SYNC_CODE, RESET_ALL_CODE};
  logic            clk        = 1'b0;
  logic            arst_n     = 1'b0;
  logic            tck        = 1'b0;
  logic            test_rst_n = 1'b0;
  logic            ms         = 1'b1;
  logic            di         = 1'b1;
  logic            force_n    = 1'b1;
  logic            sdi, dtck, drst, dms, ddo, ddo_oe, udo, udo_oe, link_n;
  link_status_type mon;
  int              err_total  = 0;
  int              cmp_count  = 0;

  always #5 clk = ~clk;
  // Test clock, phase unrelated to clk
  initial begin
    #1.7;
    forever #32 tck = ~tck;
  end

  addressable_tap_switch dut (
    .clk(clk), .arst_n(arst_n), .clk_en(1'b1),
    .upstream_test_clock(tck), .upstream_test_reset(test_rst_n),
    .upstream_mode_select(ms), .upstream_data_in(di),
    .forced_link_n(force_n), .board_id_pins(MY_ID),
    .downstream_data_in(sdi), .downstream_test_clock(dtck),
    .downstream_test_reset(drst), .downstream_mode_select(dms),
    .downstream_data_out(ddo), .downstream_data_out_oe(ddo_oe),
    .upstream_data_out(udo), .upstream_data_out_oe(udo_oe),
    .link_active_n(link_n), .monitor_status(mon));

  board_chain_model chain (.tck(dtck), .rst_n(drst), .tdi(ddo),
    .tdi_oe(ddo_oe), .tdo(sdi));

  // ********************
  // Helpers
  // ********************
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic walk(input logic [4:0] p, input int n);
    for (int i = n - 1; i >= 0; i--) @(posedge tck) ms <= p[i];
    repeat (2) @(posedge tck);
  endtask : walk

  // Start bit then ten bit pairs, msb first
  task automatic send(input logic [9:0] a, input logic bad);
    @(posedge tck) di <= 1'b0;
    for (int i = 9; i >= 0; i--) begin
      @(posedge tck) di <= a[i];
      @(posedge tck) di <= ~a[i] ^ bad;
    end
    @(posedge tck) di <= 1'b1;
  endtask : send

  task automatic ack(input logic [9:0] a);
    for (int k = 0; k < 20; k++) begin
      @(negedge tck);
      #1 chk(udo_oe, 1'b1);
      chk(udo, a[9 - k / 2] ^ k[0]);
      chk(link_n, 1'b1);
    end
    @(posedge tck);
    #1 chk(link_n, 1'b0);
  endtask : ack

  task automatic noack(input logic exp_n);
    repeat (20) begin
      @(negedge tck);
      #1 chk(udo_oe, 1'b0);
    end
    chk(link_n, exp_n);
    chk(ddo_oe, !exp_n);
  endtask : noack

  task automatic end_sim;
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  // ********************
  // Scenarios
  // ********************
  task automatic t_power_up;
    chk(link_n, 1'b1);
    chk(ddo_oe | udo_oe, 1'b0);
    chk(dms, 1'b1);
    chk(mon, ls_reset);
  endtask : t_power_up

  task automatic t_match_off;
    send(MY_ID, 1'b0);
    ack(MY_ID);
    chk(udo, sdi);
    chk(ddo, di);
    walk(5'h00, 1);
    #1 chk(dms, 1'b0);
    chk(mon, ls_on);
    send(~MY_ID, 1'b0);
    noack(1'b1);
    walk(5'h1F, 5);
    #1 chk(dms, 1'b0);
  endtask : t_match_off

  task automatic t_codes;
    foreach (CODES[i]) begin
      send(MY_ID, 1'b0);
      ack(MY_ID);
      send(CODES[i], i == 1);
      noack(1'b1);
    end
    chk(mon, ls_reset);
    chk(dms, 1'b1);
    // Mode select moves in mid-frame: hard error, no ack
    fork
      send(MY_ID, 1'b0);
      begin
        repeat (5) @(posedge tck);
        ms <= 1'b0;
      end
    join
    noack(1'b1);
    chk(mon, ls_off);
    chk(dms, 1'b1);
  endtask : t_codes

  task automatic t_group;
    walk(5'h04, 4);
    send(MY_ID, 1'b0);
    noack(1'b1);
    walk(5'h02, 2);
    send(GROUP_SYNC_CODE, 1'b0);
    noack(1'b0);
    chk(ddo, di);
    chk(dms, ms);
    walk(5'h1F, 5);
  endtask : t_group

  task automatic t_forced;
    @(posedge clk) force_n <= 1'b0;
    @(posedge clk) test_rst_n <= 1'b0;
    ms <= 1'b0;
    #1 chk(link_n, 1'b0);
    chk(dms, 1'b1);
    chk(ddo, di);
    repeat (5) @(posedge tck);
    @(posedge clk) test_rst_n <= 1'b1;
    #1 chk(link_n, 1'b0);
    chk(dms, ms);
    send(MY_ID, 1'b0);
    @(posedge clk) force_n <= 1'b1;
    #1 chk(link_n, 1'b1);
    chk(udo_oe, 1'b0);
    // A frame taken under forced link would ack or connect here
    noack(1'b1);
  endtask : t_forced

  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge tck);
    @(posedge clk) test_rst_n <= 1'b1;
    repeat (3) @(posedge tck);
    #1 t_power_up();
    t_match_off();
    t_codes();
    t_group();
    t_forced();
    end_sim();
  end

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule : testbench

bind addressable_tap_switch tap_switch_chk chk_inst (
  .clk(clk), .arst_n(arst_n),
  .upstream_test_clock(upstream_test_clock),
  .upstream_test_reset(upstream_test_reset),
  .upstream_mode_select(upstream_mode_select),
  .upstream_data_in(upstream_data_in), .forced_link_n(forced_link_n),
  .downstream_test_clock(downstream_test_clock),
  .downstream_test_reset(downstream_test_reset),
  .downstream_mode_select(downstream_mode_select),
  .downstream_data_out(downstream_data_out),
  .downstream_data_out_oe(downstream_data_out_oe),
  .upstream_data_out_oe(upstream_data_out_oe),
  .link_active_n(link_active_n));
